/* File: ctes_pkg.sv */
package ctes_pkg;
	// Trigger response modes
	localparam logic [1:0] RESP_NONE = 2'h0;
	localparam logic [1:0] RESP_SINGLE = 2'h1;
	localparam logic [1:0] RESP_PER_TRIG = 2'h2;
	localparam logic [1:0] RESP_EXPOSE_PULSE = 2'h3;
	// Shutter modes
	localparam logic [1:0] SHUT_NORMAL = 2'h0;
	localparam logic [1:0] SHUT_CLOSED = 2'h1;
	localparam logic [1:0] SHUT_OPEN = 2'h2;
	localparam logic [1:0] SHUT_OPEN_BEFORE = 2'h3;
	// Register offsets (word index on the plain port)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_EXPOSE = 4'h1;
	localparam logic [3:0] REG_OPEN_DLY = 4'h2;
	localparam logic [3:0] REG_CLOSE_DLY = 4'h3;
	localparam logic [3:0] REG_READOUT = 4'h4;
	localparam logic [3:0] REG_FRAMES = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [3:0] REG_DROPS = 4'h7;
	// Control register field positions
	localparam int CTRL_RESP_LSB = 0;
	localparam int CTRL_SHUT_LSB = 2;
	localparam int CTRL_FALL_BIT = 4;
	localparam int CTRL_START_BIT = 5;
	localparam int CTRL_STOP_BIT = 6;
	// Reset values of timing registers, in clock cycles, and of the frame count
	localparam logic [31:0] EXPOSE_RST = 32'h0000_0064;
	localparam logic [31:0] OPEN_DLY_RST = 32'h0000_0010;
	localparam logic [31:0] CLOSE_DLY_RST = 32'h0000_0010;
	localparam logic [31:0] READOUT_RST = 32'h0000_0100;
	localparam logic [31:0] FRAMES_RST = 32'h0000_0001;
	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_WAIT = 7'h02,
		ST_OPEN = 7'h04,
		ST_EXPOSE = 7'h08,
		ST_CLOSE = 7'h10,
		ST_READ = 7'h20,
		ST_REOPEN = 7'h40
	} ctes_state_t;
endpackage

/* File: ctes_trig_edge.sv */
// Trigger synchroniser and edge detector
module ctes_trig_edge (
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic trig_in, // Raw external trigger
	input wire logic fall_sel, // Falling edge selected
	output logic sel_edge, // Pulse on selected edge
	output logic end_edge // Pulse on opposite edge
);
	logic sync1_ff; // First stage, read only by second stage
	logic sync2_ff; // Second stage
	logic prev_ff; // Previous synced level
	wire rise_w = sync2_ff & ~prev_ff; // Rising edge seen
	wire fall_w = ~sync2_ff & prev_ff; // Falling edge seen

	// Two-stage synchroniser and history
	always_ff @(posedge clock) begin
		if (rst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			sync1_ff <= trig_in;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// One-cycle event per edge, polarity from the selection
	assign sel_edge = fall_sel ? fall_w : rise_w;
	assign end_edge = fall_sel ? rise_w : fall_w;

	// Edge events never fire together
	a_edge_excl: assert property (@(posedge clock) disable iff (rst) !(sel_edge && end_edge))
		else $error("selected and opposite edges together");
	// An event must trace back to the raw pin, two then three cycles earlier
	a_edge_source: assert property (@(posedge clock) disable iff (rst)
		sel_edge |-> ($past(trig_in, 2) != fall_sel) && ($past(trig_in, 3) == fall_sel))
		else $error("edge event does not match the trigger pin");
endmodule

/* File: ctes_sequencer.sv */
// What this block does
// - Single trigger starts whole programmed sequence
// - Triggered modes accept all four shutter modes
// - Per-trigger mode: each exposure needs trigger
// - Configuration picks rising or falling trigger edge
// - Per-trigger normal: trigger opens shutter, exposes
// - Normal, open-before: close shutter first, then start readout
// - Open-before: shutter open at trigger, then close
// - Open-before, per-trigger and pulse modes: reopen after readout, wait open
// - Pulse mode rising: expose rise to fall
// - Pulse mode falling: expose fall to rise
// - Triggers while busy are dropped, not queued
// - No response: ignore triggers, free-run frames
module ctes_sequencer
	import ctes_pkg::*;
#(
	parameter int TW = 32 // Width of timing counters
) (
	input wire logic clock, // 125 MHz system clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic trig_in, // External trigger input
	input wire logic [3:0] reg_addr, // Register word index
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic shutter_ff, // Shutter drive, high opens
	output logic exposing_ff, // Sensor exposing
	output logic readout_ff, // Readout running
	output logic waiting_ff // Waiting for a trigger
);
	import ctes_pkg::*;

	logic [1:0] resp_ff; // Trigger response mode
	logic [1:0] shut_ff; // Shutter mode
	logic fall_ff; // Falling edge selected
	logic [TW-1:0] expose_ff; // Exposure time
	logic [TW-1:0] open_dly_ff; // Shutter opening delay
	logic [TW-1:0] close_dly_ff; // Shutter closing delay
	logic [TW-1:0] read_ff; // Readout time
	logic [TW-1:0] frames_ff; // Frames per sequence
	logic [TW-1:0] cnt_ff; // Phase timer
	logic [TW-1:0] left_ff; // Frames remaining
	logic [15:0] drops_ff; // Dropped trigger count
	logic [31:0] rdata_ff; // Read data register
	ctes_state_t state_ff; // Sequencer state
	ctes_state_t nxt_state; // Next state
	logic sel_edge; // Selected trigger edge pulse
	logic end_edge; // Opposite trigger edge pulse

	// Edge events only, so a held level cannot retrigger
	ctes_trig_edge u_edge (
		.clock(clock),
		.rst(rst),
		.trig_in(trig_in),
		.fall_sel(fall_ff),
		.sel_edge(sel_edge),
		.end_edge(end_edge)
	);

	// Decode helpers
	wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	wire start_cmd = wr_ctrl && reg_wdata[CTRL_START_BIT];
	wire stop_cmd = wr_ctrl && reg_wdata[CTRL_STOP_BIT];
	wire is_idle = (state_ff == ST_IDLE);
	wire is_wait = (state_ff == ST_WAIT);
	wire cnt_done = (cnt_ff == '0);
	wire pulse_mode = (resp_ff == RESP_EXPOSE_PULSE);
	wire last_frame = (left_ff <= {{(TW-1){1'b0}}, 1'b1});
	// Which modes need a trigger per frame
	wire every_trig = (resp_ff == RESP_PER_TRIG) || pulse_mode;
	// A trigger outside the waiting and idle states is dropped, except with no response
	wire dropped = sel_edge && !is_wait && !is_idle && (resp_ff != RESP_NONE);
	// Opening phase is skipped when already open or shutter not driven
	wire skip_open = (shut_ff != SHUT_NORMAL);
	// Mode as it will stand, so a start sharing the mode write uses the new mode
	wire cfg_load = wr_ctrl && is_idle; // Mode write accepted
	wire [1:0] cfg_resp = cfg_load ? reg_wdata[CTRL_RESP_LSB +: 2] : resp_ff; // Effective response
	wire [1:0] cfg_shut = cfg_load ? reg_wdata[CTRL_SHUT_LSB +: 2] : shut_ff; // Effective shutter

	// Shutter level per mode and state
	function automatic logic shut_level(input logic [1:0] m, input ctes_state_t s);
		case (m)
			SHUT_CLOSED: shut_level = 1'b0;
			SHUT_OPEN: shut_level = 1'b1;
			SHUT_OPEN_BEFORE: shut_level = (s == ST_WAIT) || (s == ST_EXPOSE) || (s == ST_REOPEN);
			default: shut_level = (s == ST_OPEN) || (s == ST_EXPOSE);
		endcase
	endfunction

	// Start phase timer on entry to next state
	function automatic logic [TW-1:0] phase_len(input ctes_state_t s);
		case (s)
			ST_OPEN: phase_len = open_dly_ff;
			ST_EXPOSE: phase_len = expose_ff;
			ST_CLOSE: phase_len = close_dly_ff;
			ST_READ: phase_len = read_ff;
			ST_REOPEN: phase_len = open_dly_ff;
			default: phase_len = '0;
		endcase
	endfunction

	// Next-state logic
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_cmd) begin
					if (cfg_resp == RESP_NONE)
						nxt_state = (cfg_shut != SHUT_NORMAL) ? ST_EXPOSE : ST_OPEN;
					else if (cfg_shut == SHUT_OPEN_BEFORE)
						nxt_state = ST_REOPEN;
					else
						nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sel_edge)
					nxt_state = (skip_open || pulse_mode) && shut_ff != SHUT_NORMAL ?
						ST_EXPOSE : (pulse_mode ? ST_EXPOSE : ST_OPEN);
			end
			ST_OPEN: begin
				if (cnt_done)
					nxt_state = ST_EXPOSE;
			end
			ST_EXPOSE: begin
				// Pulse mode ends on the opposite edge, others on time
				if (pulse_mode ? end_edge : cnt_done)
					nxt_state = (shut_ff == SHUT_NORMAL || shut_ff == SHUT_OPEN_BEFORE) ?
						ST_CLOSE : ST_READ;
			end
			ST_CLOSE: begin
				if (cnt_done)
					nxt_state = ST_READ;
			end
			ST_READ: begin
				if (cnt_done) begin
					if (last_frame)
						nxt_state = ST_IDLE;
					else if (!every_trig)
						nxt_state = skip_open ? ST_EXPOSE : ST_OPEN;
					else if (shut_ff == SHUT_OPEN_BEFORE)
						nxt_state = ST_REOPEN;
					else
						nxt_state = ST_WAIT;
				end
			end
			ST_REOPEN: begin
				if (cnt_done)
					nxt_state = ST_WAIT;
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (stop_cmd)
			nxt_state = ST_IDLE;
	end

	// State, timers and frame counter
	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
			left_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				cnt_ff <= phase_len(nxt_state);
			else if (!cnt_done)
				cnt_ff <= cnt_ff - {{(TW-1){1'b0}}, 1'b1};
			if (is_idle && start_cmd)
				left_ff <= frames_ff;
			else if (state_ff == ST_READ && nxt_state != ST_READ)
				left_ff <= left_ff - {{(TW-1){1'b0}}, 1'b1};
		end
	end

	// Registered status outputs
	always_ff @(posedge clock) begin
		if (rst) begin
			shutter_ff <= 1'b0;
			exposing_ff <= 1'b0;
			readout_ff <= 1'b0;
			waiting_ff <= 1'b0;
		end else begin
			shutter_ff <= shut_level(cfg_shut, nxt_state);
			exposing_ff <= (nxt_state == ST_EXPOSE);
			readout_ff <= (nxt_state == ST_READ);
			waiting_ff <= (nxt_state == ST_WAIT);
		end
	end

	// Register writes; drop counter saturates
	always_ff @(posedge clock) begin
		if (rst) begin
			resp_ff <= RESP_NONE;
			shut_ff <= SHUT_NORMAL;
			fall_ff <= 1'b0;
			expose_ff <= TW'(EXPOSE_RST);
			open_dly_ff <= TW'(OPEN_DLY_RST);
			close_dly_ff <= TW'(CLOSE_DLY_RST);
			read_ff <= TW'(READOUT_RST);
			frames_ff <= TW'(FRAMES_RST);
			drops_ff <= 16'h0000;
		end else begin
			// Mode changes only while idle, so a running frame keeps its mode
			if (wr_ctrl && is_idle) begin
				resp_ff <= reg_wdata[CTRL_RESP_LSB +: 2];
				shut_ff <= reg_wdata[CTRL_SHUT_LSB +: 2];
				fall_ff <= reg_wdata[CTRL_FALL_BIT];
			end
			if (reg_wr && reg_addr == REG_EXPOSE)
				expose_ff <= reg_wdata[TW-1:0];
			if (reg_wr && reg_addr == REG_OPEN_DLY)
				open_dly_ff <= reg_wdata[TW-1:0];
			if (reg_wr && reg_addr == REG_CLOSE_DLY)
				close_dly_ff <= reg_wdata[TW-1:0];
			if (reg_wr && reg_addr == REG_READOUT)
				read_ff <= reg_wdata[TW-1:0];
			if (reg_wr && reg_addr == REG_FRAMES)
				frames_ff <= reg_wdata[TW-1:0];
			// Set wins: a drop beats a clearing write, even when saturated
			if (dropped) begin
				if (drops_ff != 16'hFFFF)
					drops_ff <= drops_ff + 16'h0001;
			end else if (reg_wr && reg_addr == REG_DROPS) begin
				drops_ff <= 16'h0000;
			end
		end
	end

	// Read mux
	wire [31:0] ctrl_rd = {27'h0, fall_ff, shut_ff, resp_ff};
	wire [31:0] stat_rd = {16'h0, 9'h0, state_ff};
	wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? ctrl_rd :
		(reg_addr == REG_EXPOSE) ? 32'(expose_ff) :
		(reg_addr == REG_OPEN_DLY) ? 32'(open_dly_ff) :
		(reg_addr == REG_CLOSE_DLY) ? 32'(close_dly_ff) :
		(reg_addr == REG_READOUT) ? 32'(read_ff) :
		(reg_addr == REG_FRAMES) ? 32'(frames_ff) :
		(reg_addr == REG_STATUS) ? stat_rd :
		(reg_addr == REG_DROPS) ? {16'h0, drops_ff} : 32'h0000_0000;

	// Read data valid only the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
	end
	assign reg_rdata = rdata_ff;

	// Assertions
	// Close phase followed by readout
	sequence s_close_done;
		(state_ff == ST_CLOSE) ##1 (state_ff == ST_READ);
	endsequence
	// Readout finishing with frames still to take
	sequence s_more_frames;
		state_ff == ST_READ && cnt_done && !last_frame && !stop_cmd;
	endsequence

	a_close_before_read: assert property (@(posedge clock) disable iff (rst)
		(state_ff == ST_EXPOSE && nxt_state == ST_CLOSE && !stop_cmd) |=> !readout_ff)
		else $error("readout started before shutter closed");
	a_read_after_close: assert property (@(posedge clock) disable iff (rst)
		s_close_done |-> !shutter_ff || shut_ff == SHUT_OPEN)
		else $error("shutter open at readout in normal mode");
	a_drop_no_effect: assert property (@(posedge clock) disable iff (rst)
		(dropped && !cnt_done && !stop_cmd) |=> $stable(state_ff))
		else $error("dropped trigger changed state");
	// Every drop below saturation lands in the counter, a clearing write notwithstanding
	a_drop_counted: assert property (@(posedge clock) disable iff (rst)
		(dropped && drops_ff != 16'hFFFF) |=> drops_ff == $past(drops_ff) + 16'h0001)
		else $error("dropped trigger not counted");
	a_none_ignores: assert property (@(posedge clock) disable iff (rst)
		(resp_ff == RESP_NONE) |-> !is_wait)
		else $error("waiting for trigger in no-response mode");
	a_closed_mode: assert property (@(posedge clock) disable iff (rst)
		(shut_ff == SHUT_CLOSED && $stable(shut_ff) && !cfg_load) |=> !shutter_ff)
		else $error("shutter driven in always-closed mode");
	a_open_mode: assert property (@(posedge clock) disable iff (rst)
		(shut_ff == SHUT_OPEN && $stable(shut_ff) && !cfg_load) |=> shutter_ff)
		else $error("shutter shut in always-open mode");
	a_wait_open_before: assert property (@(posedge clock) disable iff (rst)
		(is_wait && shut_ff == SHUT_OPEN_BEFORE) |-> shutter_ff)
		else $error("shutter not open while waiting in open-before mode");
	a_trig_opens: assert property (@(posedge clock) disable iff (rst)
		(is_wait && sel_edge && shut_ff == SHUT_NORMAL && !pulse_mode && !stop_cmd)
		|=> shutter_ff && state_ff == ST_OPEN)
		else $error("trigger did not open shutter");
	a_pulse_start: assert property (@(posedge clock) disable iff (rst)
		(is_wait && sel_edge && pulse_mode && !stop_cmd) |=> exposing_ff)
		else $error("exposure did not start on selected edge");
	a_pulse_end: assert property (@(posedge clock) disable iff (rst)
		(state_ff == ST_EXPOSE && pulse_mode && end_edge && !stop_cmd) |=> !exposing_ff)
		else $error("exposure did not end on opposite edge");
	a_per_trig_wait: assert property (@(posedge clock) disable iff (rst)
		s_more_frames ##0 (resp_ff == RESP_PER_TRIG && shut_ff != SHUT_OPEN_BEFORE) |=> waiting_ff)
		else $error("next frame started without its own trigger");
	a_single_runs: assert property (@(posedge clock) disable iff (rst)
		s_more_frames ##0 (resp_ff == RESP_SINGLE) |=> !waiting_ff)
		else $error("single-trigger sequence waited for another trigger");
endmodule

/* File: ctes_trig_src.sv */
// Far side: experiment trigger source and mechanical shutter
module ctes_trig_src (
	input wire logic clock, // System clock
	input wire logic shutter_ff, // Shutter drive from the camera
	output logic trig_in // Trigger line into the camera
);
	timeunit 1ns;
	timeprecision 1ps;
	logic idle_hi = 1'b0; // Level the line rests at between pulses
	int open_cyc = 0; // Cycles the blades have been driven open
	initial trig_in = 1'b0;
	// Blades need time to open; a trigger fired early would lose light
	always @(posedge clock) begin
		open_cyc <= shutter_ff ? open_cyc + 1 : 0;
	end
	// Choose the rest level; the edge it makes is seen while idle
	task automatic set_idle(input logic v);
		idle_hi = v;
		trig_in <= v;
	endtask
	// One pulse of w cycles, starting at the next clock edge
	task automatic pulse(input int w);
		@(posedge clock) trig_in <= !idle_hi;
		repeat (w) @(posedge clock);
		trig_in <= idle_hi;
	endtask
endmodule

/* File: ctes_sequencer_bench.sv */
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
// Self-checking bench for the trigger and exposure sequencer
module ctes_sequencer_bench
	import ctes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0; // 125 MHz clock
	logic rst; // Synchronous reset
	logic trig_in; // Trigger from the source
	logic [3:0] reg_addr; // Register index
	logic [31:0] reg_wdata; // Write data
	logic reg_wr; // Write strobe
	logic reg_rd; // Read strobe
	logic [31:0] reg_rdata, d; // Read data, last read value
	logic shutter_ff, exposing_ff, readout_ff, waiting_ff; // Sequencer outputs
	int err_total = 0, checks = 0, seed = 32'hB42E, e_len, w; // Counters, seed, lengths
	int exp_cyc, rd_starts; // Exposure cycles, readouts begun
	logic rd_q = 1'b0, sh_on, sh_gap, sh_rd; // Shutter observations
	always #4 clock = !clock;
	ctes_sequencer u_dut (.clock(clock), .rst(rst), .trig_in(trig_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.shutter_ff(shutter_ff), .exposing_ff(exposing_ff), .readout_ff(readout_ff),
		.waiting_ff(waiting_ff));
	ctes_trig_src u_src (.clock(clock), .shutter_ff(shutter_ff), .trig_in(trig_in));
	// Watch phases and the shutter through each sequence
	always @(posedge clock) begin
		rd_q <= readout_ff;
		if (exposing_ff) exp_cyc <= exp_cyc + 1;
		if (readout_ff && !rd_q) rd_starts <= rd_starts + 1;
		if (readout_ff && !rd_q) sh_rd <= shutter_ff;
		if (shutter_ff) sh_on <= 1'b1;
		if (exposing_ff && !shutter_ff) sh_gap <= 1'b1;
	end
	// Off the edge, so the monitor's pending updates cannot undo the clear
	task automatic clr;
		#1 exp_cyc = 0;
		rd_starts = 0;
		sh_on = 1'b0;
		sh_gap = 1'b0;
		sh_rd = 1'b0;
	endtask
	task automatic end_of_test;
		if (err_total == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Starts on a fresh edge, so back-to-back calls never touch a strobe twice in one step
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return waiting_ff;
			1: return exposing_ff;
			default: return readout_ff;
		endcase
	endfunction
	// Bounded wait for an output to reach a level
	task automatic wait_on(input int s, input logic v);
		int n;
		n = 0;
		#1;
		while (pick(s) !== v && n < 5000) begin
			@(posedge clock);
			#1 n++;
		end
		if (n >= 5000) begin
			err_total++;
			end_of_test();
		end
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] r, input logic [1:0] sm, input logic f);
		ctl = 32'h0;
		ctl[CTRL_RESP_LSB +: 2] = r;
		ctl[CTRL_SHUT_LSB +: 2] = sm;
		ctl[CTRL_FALL_BIT] = f;
		ctl[CTRL_START_BIT] = 1'b1;
	endfunction
	// Start a free-running or single-trigger run and count its frames
	task automatic run(input logic [1:0] r, input int n);
		wr(REG_FRAMES, n);
		wr(REG_DROPS, 32'h0);
		wr(REG_CTRL, ctl(r, SHUT_NORMAL, 1'b0));
		clr();
		repeat (20) @(posedge clock);
		u_src.pulse(3);
		for (int k = 0; k < n; k++) begin
			if (k == 1) u_src.pulse(3);
			wait_on(2, 1'b1);
			wait_on(2, 1'b0);
		end
		repeat (30) @(posedge clock);
		#1 `CHK("frames", n, rd_starts)
		`CHK("idle", 1'b0, waiting_ff)
	endtask
	initial begin
		rst <= 1'b1;
		reg_addr <= 4'h0;
		reg_wdata <= 32'h0000_0000;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		u_src.set_idle(1'b0);
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(REG_EXPOSE);
		`CHK("expose_rst", EXPOSE_RST, d)
		rd(REG_OPEN_DLY);
		`CHK("open_rst", OPEN_DLY_RST, d)
		rd(REG_READOUT);
		`CHK("read_rst", READOUT_RST, d)
		rd(REG_FRAMES);
		`CHK("frames_rst", FRAMES_RST, d)
		rd(REG_STATUS);
		`CHK("status_rst", 32'h1, d)
		rd(4'h9);
		`CHK("unmapped", 32'h0, d)
		e_len = 8 + ($unsigned($random(seed)) % 16);
		wr(REG_EXPOSE, e_len);
		wr(REG_OPEN_DLY, 32'h4);
		wr(REG_CLOSE_DLY, 32'h4);
		wr(REG_READOUT, 32'h14);
		wr(REG_FRAMES, 32'h2);
		// Every shutter mode under per-trigger response
		for (int s = 0; s < 4; s++) begin
			u_src.set_idle(s[0]);
			wr(REG_DROPS, 32'h0);
			wr(REG_CTRL, ctl(RESP_PER_TRIG, s[1:0], s[0]));
			clr();
			for (int k = 0; k < 2; k++) begin
				repeat (20) @(posedge clock);
				#1 `CHK("waiting", 2'h2, {waiting_ff, exposing_ff})
				if (s == 3) `CHK("open_wait", 1'b1, shutter_ff)
				u_src.pulse(3);
				wait_on(1, 1'b1);
				if (s != 1) `CHK("open_lead", 1'b1, u_src.open_cyc >= 4)
				u_src.pulse(2);
				wait_on(2, 1'b1);
				wait_on(2, 1'b0);
			end
			`CHK("expose", 1'b1, exp_cyc >= 2 * e_len && exp_cyc <= 2 * e_len + 2)
			if (s != 1) `CHK("gap", 1'b0, sh_gap)
			if (s == 1) `CHK("shut_on", 1'b0, sh_on)
			`CHK("shut_rd", s == 2, sh_rd)
			@(posedge clock);
			rd(REG_DROPS);
			`CHK("drops", 32'h2, d)
			wr(REG_CTRL, 32'h1 << CTRL_STOP_BIT);
			repeat (4) @(posedge clock);
		end
		u_src.set_idle(1'b0);
		run(RESP_SINGLE, 3);
		run(RESP_NONE, 2);
		rd(REG_DROPS);
		`CHK("none_drops", 32'h0, d)
		// Exposure follows the pulse width, either polarity
		for (int f = 0; f < 2; f++) begin
			u_src.set_idle(f[0]);
			wr(REG_FRAMES, 32'h1);
			wr(REG_CTRL, ctl(RESP_EXPOSE_PULSE, SHUT_NORMAL, f[0]));
			wait_on(0, 1'b1);
			w = 10 + ($unsigned($random(seed)) % 31);
			clr();
			u_src.pulse(w);
			wait_on(2, 1'b1);
			`CHK("pulse_exp", 1'b1, exp_cyc >= w - 2 && exp_cyc <= w + 2)
			wait_on(2, 1'b0);
		end
		end_of_test();
	end
endmodule
